// File: hw/sssm_cfg.svh
// Offsets, field positions, reset values and widths of the socket status registers
`ifndef SSSM_CFG_SVH
`define SSSM_CFG_SVH

// Register byte offsets
`define SSSM_OFS_EVENT        5'h00
`define SSSM_OFS_MASK         5'h04
`define SSSM_OFS_STATE        5'h08
`define SSSM_OFS_FORCE        5'h0c
`define SSSM_ADDR_W           5

// Event and mask fields
`define SSSM_EVT_W            4
`define SSSM_BIT_POWER        3
`define SSSM_BIT_DETECT2      2
`define SSSM_BIT_DETECT1      1
`define SSSM_BIT_STATUS       0
`define SSSM_MASK_RESET       4'h0
`define SSSM_EVENT_RESET      4'h0
`define SSSM_DETECT_MASK_ON   2'h3

// Present-state fields
`define SSSM_BIT_SOCK_Y       31
`define SSSM_BIT_SOCK_X       30
`define SSSM_BIT_SOCK_3V3     29
`define SSSM_BIT_SOCK_5V      28
`define SSSM_CARD_V_HI        13
`define SSSM_CARD_V_LO        10
`define SSSM_BIT_BAD_SUPPLY   9
`define SSSM_BIT_DATA_LOST    8
`define SSSM_BIT_NOT_CARD     7
`define SSSM_BIT_READY        6
`define SSSM_BIT_CARDBUS      5
`define SSSM_BIT_16BIT        4
`define SSSM_SOCK_CAPS        4'h3
`define SSSM_CARD_V_RESET     4'h0

// Synchronised pin lanes
`define SSSM_PIN_W            4
`define SSSM_PIN_STATUS       0
`define SSSM_PIN_DETECT1      1
`define SSSM_PIN_DETECT2      2
`define SSSM_PIN_READY        3
`define SSSM_PIN_RESET        4'h6

`endif

// File: hw/sssm_pkg.sv
// Types shared by the socket status and mask logic
package sssm_pkg;
   typedef logic [31:0] sssm_word_t;
   typedef logic [3:0]  sssm_evt_t;
   typedef struct packed {
      logic [3:0] card_v;
      logic       not_card;
      logic       cardbus;
      logic       bit16;
   } sssm_card_t;
endpackage : sssm_pkg

// File: hw/sssm_pin_if.sv
// Synchronised socket pin levels and edges
`include "sssm_cfg.svh"
interface sssm_pin_if;
   logic [`SSSM_PIN_W-1:0] level;
   logic [`SSSM_PIN_W-1:0] rise;
   logic [`SSSM_PIN_W-1:0] fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : sssm_pin_if

// File: hw/sssm_pin_sync.sv
// Two-stage synchroniser and edge detector for the socket pins
`include "sssm_cfg.svh"
module sssm_pin_sync
   import sssm_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic [`SSSM_PIN_W-1:0] pins_in,
   sssm_pin_if.src                     pin_if
);
   logic [`SSSM_PIN_W-1:0] meta_ff;
   logic [`SSSM_PIN_W-1:0] sync_ff;
   logic [`SSSM_PIN_W-1:0] last_ff;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta_ff <= `SSSM_PIN_RESET;
         sync_ff <= `SSSM_PIN_RESET;
         last_ff <= `SSSM_PIN_RESET;
      end else begin
         meta_ff <= pins_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign pin_if.level = sync_ff;
   assign pin_if.rise  = sync_ff & ~last_ff;
   assign pin_if.fall  = ~sync_ff & last_ff;
endmodule : sssm_pin_sync

// File: hw/sssm_regs.sv
// Socket event, mask, present-state and force-event registers for one card socket
// Function
// - Event bits set on their conditions whatever the mask holds.
// - Mask bits 31 to 4 read zero and ignore writes.
// - Power change interrupts only while power_cycle_mask is 1.
// - Card detect interrupts only while card_detect_mask is 11.
// - Status pin interrupts only while card_status_change_mask is 1.
// - Force-event writes show up in the present-state register.
// - Card voltage and type flags latched on each completed identification or force write.
// - Card detect levels frozen while card identification runs.
// - Socket Y and X supply flags read 0.
// - Socket 3.3 V and 5 V supply flags read 1.
// - Present-state bits 27 to 14 read zero.
// - Four read-only card voltage support flags.
// - bad_supply_request set on an invalid power request.
// - removal_data_lost set when removal lost a cycle or data.
// - unrecognized_card held until a valid card is inserted.
// - Writing 1 clears an event bit; reset clears them all.
// - Status event on rising edge for CardBus, both edges otherwise.
// - detect_pin_one_level follows the first card detect pin.
`include "sssm_cfg.svh"
module sssm_regs
   import sssm_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic [`SSSM_ADDR_W-1:0] reg_addr_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   input  wire logic [31:0]             reg_wdata_in,
   output      logic [31:0]             reg_rdata_out,
   input  wire logic                    card_detect_pin_one_in,
   input  wire logic                    card_detect_pin_two_in,
   input  wire logic                    status_change_pin_in,
   input  wire logic                    ready_pin_in,
   input  wire logic                    socket_powered_in,
   input  wire logic                    interrogation_busy_in,
   input  wire logic                    interrogation_done_in,
   input  wire logic [3:0]              card_supports_in,
   input  wire logic                    card_is_cardbus_in,
   input  wire logic                    card_is_16bit_in,
   input  wire logic                    card_unrecognized_in,
   input  wire logic                    bad_supply_request_in,
   input  wire logic                    removal_data_lost_in,
   output      logic                    card_status_change_interrupt_out
);
   sssm_pin_if pin_if ();

   sssm_evt_t  event_ff;
   sssm_evt_t  nxt_event;
   sssm_evt_t  mask_ff;
   sssm_card_t card_ff;
   sssm_card_t nxt_card;
   logic [1:0] detect_ff;
   logic       powered_ff;
   logic       bad_supply_ff;
   logic       nxt_bad_supply;
   logic       data_lost_ff;
   logic       nxt_data_lost;
   logic       irq_ff;
   logic [31:0] rdata_ff;

   function automatic logic hit(input logic [`SSSM_ADDR_W-1:0] a,
                                input logic [`SSSM_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   sssm_pin_sync u_pin_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .pins_in  ({ready_pin_in, card_detect_pin_two_in, card_detect_pin_one_in,
                  status_change_pin_in}),
      .pin_if   (pin_if)
   );

   // Address decode
   wire wr_event = reg_wr_in & hit(reg_addr_in, `SSSM_OFS_EVENT);
   wire wr_mask  = reg_wr_in & hit(reg_addr_in, `SSSM_OFS_MASK);
   wire wr_force = reg_wr_in & hit(reg_addr_in, `SSSM_OFS_FORCE);

   // Event causes
   wire [1:0] detect_live = {pin_if.level[`SSSM_PIN_DETECT2], pin_if.level[`SSSM_PIN_DETECT1]};
   wire [1:0] detect_chg  = interrogation_busy_in ? 2'h0 : (detect_live ^ detect_ff);
   wire       power_chg   = socket_powered_in ^ powered_ff;
   wire       status_evt  = pin_if.rise[`SSSM_PIN_STATUS] |
                            (~card_ff.cardbus & pin_if.fall[`SSSM_PIN_STATUS]);
   wire [3:0] cause       = {power_chg, detect_chg, status_evt};
   wire [3:0] force_evt   = wr_force ? reg_wdata_in[3:0] : 4'h0;
   wire [3:0] clear_evt   = wr_event ? reg_wdata_in[3:0] : 4'h0;

   // Set wins over a write-one clear, independent of the mask
   assign nxt_event = (event_ff & ~clear_evt) | cause | force_evt;

   // Interrupt enables per event bit
   wire       detect_en = (mask_ff[`SSSM_BIT_DETECT2:`SSSM_BIT_DETECT1] ==
                           `SSSM_DETECT_MASK_ON);
   wire [3:0] irq_en    = {mask_ff[`SSSM_BIT_POWER], detect_en, detect_en,
                           mask_ff[`SSSM_BIT_STATUS]};
   wire       nxt_irq   = |(nxt_event & irq_en);

   // Card information latched on each completed identification, or forced
   always_comb begin
      nxt_card = card_ff;
      if (interrogation_done_in) begin
         nxt_card.card_v  = card_supports_in;
         nxt_card.cardbus = card_is_cardbus_in;
         nxt_card.bit16   = card_is_16bit_in;
         nxt_card.not_card = card_unrecognized_in;
      end
      if (wr_force) begin
         nxt_card.card_v   = reg_wdata_in[`SSSM_CARD_V_HI:`SSSM_CARD_V_LO];
         nxt_card.not_card = reg_wdata_in[`SSSM_BIT_NOT_CARD];
         nxt_card.cardbus  = reg_wdata_in[`SSSM_BIT_CARDBUS];
         nxt_card.bit16    = reg_wdata_in[`SSSM_BIT_16BIT];
      end
   end

   // A hardware set in the cycle of a force write of 0 still wins
   assign nxt_bad_supply = bad_supply_request_in |
                           (wr_force ? reg_wdata_in[`SSSM_BIT_BAD_SUPPLY] :
                            bad_supply_ff);
   assign nxt_data_lost  = removal_data_lost_in |
                           (wr_force ? reg_wdata_in[`SSSM_BIT_DATA_LOST] :
                            (data_lost_ff & ~interrogation_done_in));

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         event_ff <= `SSSM_EVENT_RESET;
         mask_ff  <= `SSSM_MASK_RESET;
         irq_ff   <= 1'b0;
      end else begin
         event_ff <= nxt_event;
         irq_ff   <= nxt_irq;
         if (wr_mask) begin
            mask_ff <= reg_wdata_in[`SSSM_EVT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         card_ff       <= '{card_v: `SSSM_CARD_V_RESET, not_card: 1'b0,
                            cardbus: 1'b0, bit16: 1'b0};
         bad_supply_ff <= 1'b0;
         data_lost_ff  <= 1'b0;
         powered_ff    <= 1'b0;
         detect_ff     <= 2'h3;
      end else begin
         card_ff       <= nxt_card;
         bad_supply_ff <= nxt_bad_supply;
         data_lost_ff  <= nxt_data_lost;
         powered_ff    <= socket_powered_in;
         if (!interrogation_busy_in) begin
            detect_ff <= detect_live;
         end
      end
   end

   // Present-state word
   wire [31:0] state_word = {`SSSM_SOCK_CAPS,
                             14'h0,
                             card_ff.card_v, bad_supply_ff, data_lost_ff, card_ff.not_card,
                             pin_if.level[`SSSM_PIN_READY], card_ff.cardbus, card_ff.bit16,
                             powered_ff, detect_ff, pin_if.level[`SSSM_PIN_STATUS]};

   wire [31:0] rd_mux = hit(reg_addr_in, `SSSM_OFS_EVENT) ? {28'h0, event_ff} :
                        hit(reg_addr_in, `SSSM_OFS_MASK)  ? {28'h0, mask_ff} :
                        hit(reg_addr_in, `SSSM_OFS_STATE) ? state_word : 32'h0;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_ff <= 32'h0;
      end else if (reg_rd_in) begin
         rdata_ff <= rd_mux;
      end
   end

   assign reg_rdata_out                    = rdata_ff;
   assign card_status_change_interrupt_out = irq_ff;
endmodule : sssm_regs

// File: test/sssm_card_model.sv
// Card model that drives the socket pins
module sssm_card_model (
   input  wire logic insert_in,
   input  wire logic sts_in,
   output wire logic cd1_out,
   output wire logic cd2_out,
   output wire logic sts_out,
   output wire logic rdy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Detect pins are pulled up with no card; the status line is pulled down
   assign cd1_out = !insert_in;
   assign cd2_out = !insert_in;
   assign sts_out = insert_in && sts_in;
   assign rdy_out = 1'b1;
endmodule // sssm_card_model

// File: test/sssm_regs_sva.sv
// Assertions on the socket status register ports
module sssm_regs_sva (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [4:0]  reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        card_detect_pin_one_in,
   input wire logic        interrogation_busy_in,
   input wire logic        interrogation_done_in,
   input wire logic [3:0]  card_supports_in,
   input wire logic        card_unrecognized_in,
   input wire logic        bad_supply_request_in,
   input wire logic        card_status_change_interrupt_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   wire       rd_s = reg_rd_in && reg_addr_in == 5'h08;
   wire       wr_f = reg_wr_in && reg_addr_in == 5'h0c;
   wire       wr_m = reg_wr_in && reg_addr_in == 5'h04;
   wire       irq  = card_status_change_interrupt_out;
   wire [1:0] det  = reg_rdata_out[2:1];
   wire [3:0] cv   = reg_rdata_out[13:10];
   sequence s_quiet;
      rst_n_in && !interrogation_busy_in && $stable(card_detect_pin_one_in);
   endsequence
   sequence s_frozen;
      interrogation_busy_in [*4] ##0 rd_s ##1 interrogation_busy_in ##1 interrogation_busy_in && rd_s;
   endsequence
   a_mask_rsvd_zero: assert property (reg_rd_in && reg_addr_in == 5'h04
      |=> reg_rdata_out[31:4] == 28'h0) else $error("mask reserved bits set");
   a_state_fixed_bits: assert property (rd_s |=> reg_rdata_out[31:14] == 18'h0c000)
      else $error("fixed state bits wrong");
   a_mask_blocks_irq: assert property (wr_m && reg_wdata_in[3:0] inside {4'h0, 4'h2, 4'h4}
      ##1 !wr_m |=> !irq) else $error("masked event raised interrupt");
   a_forced_irq: assert property (wr_m && reg_wdata_in[0] ##1 !reg_wr_in ##1 wr_f && reg_wdata_in[0]
      |=> irq) else $error("forced event gave no interrupt");
   a_detect_frozen: assert property (s_frozen |=> det == $past(det, 2))
      else $error("detect bits moved during identification");
   a_detect_follow: assert property (s_quiet [*5] ##0 rd_s
      |=> reg_rdata_out[1] == $past(card_detect_pin_one_in)) else $error("detect bit wrong");
   a_card_latch: assert property (interrogation_done_in && !wr_f ##1 (!interrogation_done_in && !wr_f) [*2] ##0 rd_s
      |=> cv == $past(card_supports_in, 3) && reg_rdata_out[7] == $past(card_unrecognized_in, 3))
      else $error("card info not latched");
   a_bad_sticky: assert property (bad_supply_request_in && !wr_f ##1 (!wr_f) [*2] ##0 rd_s
      |=> reg_rdata_out[9]) else $error("bad supply flag not held");
endmodule // sssm_regs_sva

// File: test/sssm_regs_tb.sv
// Self-checking bench for the socket status registers
module sssm_regs_tb;
   import sssm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, ins = 0, sts = 0;
   logic socket_powered_in = 0, interrogation_busy_in = 0, interrogation_done_in = 0;
   logic card_is_cardbus_in = 0, card_is_16bit_in = 0, card_unrecognized_in = 0;
   logic bad_supply_request_in = 0, removal_data_lost_in = 0;
   logic [4:0] reg_addr_in = 0;
   logic [3:0] card_supports_in = 0;
   sssm_word_t reg_wdata_in = 0, reg_rdata_out, d, w;
   logic card_detect_pin_one_in, card_detect_pin_two_in, status_change_pin_in, ready_pin_in;
   logic card_status_change_interrupt_out;
   int errors = 0, compares = 0, seed = 32'hfb0b;
   sssm_evt_t ms [6] = '{4'h0, 4'h8, 4'h6, 4'h1, 4'h2, 4'h4};
   sssm_regs dut (.*);
   sssm_card_model card (.insert_in(ins), .sts_in(sts), .cd1_out(card_detect_pin_one_in),
      .cd2_out(card_detect_pin_two_in), .sts_out(status_change_pin_in), .rdy_out(ready_pin_in));
   initial forever #50 clk_in = !clk_in;
   function automatic logic irq_exp(sssm_evt_t m, sssm_evt_t ev);
      return |(ev & {m[3], m[2] & m[1], m[2] & m[1], m[0]});
   endfunction
   function automatic sssm_word_t card_exp(sssm_word_t v);
      return {18'h0, v[3:0], 2'h0, v[4], 2'h1, v[5], 4'h0};
   endfunction
   task automatic chk(input sssm_word_t got, input sssm_word_t exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input sssm_word_t v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1;
      @(posedge clk_in);
      reg_wr_in <= 0;
   endtask
   task automatic rd(input logic [4:0] a, output sssm_word_t v);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1;
      @(posedge clk_in);
      reg_rd_in <= 0;
      #1 v = reg_rdata_out;
   endtask
   task automatic conclude;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_in);
      errors++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1;
      // Let the pin synchronisers flush before the first read
      repeat (3) @(posedge clk_in);
      rd(5'h08, d);
      chk(d, 32'h3000_0046);
      repeat (8) begin
         w = $random(seed);
         wr(5'h04, w);
         rd(5'h04, d);
         chk(d, w & 32'hf);
      end
      wr(5'h04, 32'h1);
      wr(5'h0c, 32'hf);
      rd(5'h00, d);
      chk(d, 32'hf);
      foreach (ms[i]) begin
         wr(5'h04, {28'h0, ms[i]});
         repeat (2) @(posedge clk_in);
         #1;
         chk({31'h0, card_status_change_interrupt_out}, {31'h0, irq_exp(ms[i], 4'hf)});
      end
      wr(5'h00, 32'hf);
      socket_powered_in <= 1;
      repeat (3) @(posedge clk_in);
      rd(5'h00, d);
      chk(d, 32'h8);
      chk({31'h0, card_status_change_interrupt_out}, 32'h0);
      wr(5'h00, 32'hf);
      interrogation_busy_in <= 1;
      ins <= 1;
      repeat (6) @(posedge clk_in);
      rd(5'h08, d);
      rd(5'h08, d);
      chk(d & 32'h6, 32'h6);
      w = $random(seed);
      card_supports_in <= w[3:0];
      card_unrecognized_in <= w[4];
      card_is_cardbus_in <= 1;
      card_is_16bit_in <= w[5];
      @(posedge clk_in);
      interrogation_done_in <= 1;
      @(posedge clk_in);
      interrogation_done_in <= 0;
      card_supports_in <= ~w[3:0];
      rd(5'h08, d);
      chk(d & 32'h3cb0, card_exp(w));
      interrogation_busy_in <= 0;
      repeat (5) @(posedge clk_in);
      rd(5'h08, d);
      chk(d & 32'h3cb6, card_exp(w));
      rd(5'h00, d);
      chk(d, 32'h6);
      wr(5'h00, 32'hf);
      sts <= 1;
      repeat (4) @(posedge clk_in);
      rd(5'h00, d);
      chk(d, 32'h1);
      wr(5'h00, 32'h1);
      sts <= 0;
      repeat (4) @(posedge clk_in);
      rd(5'h00, d);
      chk(d, 32'h0);
      // A 16-bit card sets the status event on both pin edges
      wr(5'h0c, 32'h10);
      sts <= 1;
      repeat (4) @(posedge clk_in);
      rd(5'h00, d);
      chk(d, 32'h1);
      wr(5'h00, 32'h1);
      sts <= 0;
      repeat (4) @(posedge clk_in);
      rd(5'h00, d);
      chk(d, 32'h1);
      wr(5'h00, 32'h1);
      repeat (4) begin
         w = $random(seed) & 32'h3fb0;
         wr(5'h0c, w);
         rd(5'h08, d);
         chk(d & 32'h3fb0, w);
      end
      bad_supply_request_in <= 1;
      removal_data_lost_in <= 1;
      @(posedge clk_in);
      bad_supply_request_in <= 0;
      removal_data_lost_in <= 0;
      rd(5'h08, d);
      chk(d & 32'h300, 32'h300);
      conclude();
   end
endmodule // sssm_regs_tb
bind sssm_regs sssm_regs_sva sva (.*);
